//--- adc_seq_consts.svh
/*
  Constants for the converter sequencer: calibration pulse timing, calibration
  length, power-up waits and pipeline latency, all in input clock cycles.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

`define CLK_PERIOD_NS      8
`define SAMPLE_WIDTH       8
`define FIFO_DEPTH         4
`define PIPE_LATENCY       13
`define CAL_LOW_MIN        1280
`define CAL_HIGH_MIN       1280
`define CAL_RUN_CYCLES     1400000
`define WAIT_SHORT_CYCLES  64'h0000_0000_0400_0000
`define WAIT_LONG_CYCLES   64'h0000_0001_0000_0000
`define PULSE_CNT_WIDTH    11
`define WAIT_CNT_WIDTH     33

`endif

//--- adc_seq_pkg.sv
/*
  Types for the converter sequencer.
  Assumes adc_seq_consts.svh supplies the numeric constants.
*/
`include "adc_seq_consts.svh"

package adc_seq_pkg;
  typedef logic [`SAMPLE_WIDTH-1:0] sample_t;
  typedef struct packed {
    sample_t i_word;
    sample_t q_word;
  } pair_t;
  typedef enum logic [1:0] {
    ST_POWERUP = 2'h0,
    ST_NORMAL  = 2'h1,
    ST_CAL     = 2'h2
  } cal_state_t;
endpackage

//--- fifo_if.sv
/*
  Valid/ready carrier between the sample path and the sample FIFO.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns

interface fifo_if #(parameter int WIDTH = 16);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

//--- sample_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ns

module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Carrier
  fifo_if.fifo      port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             not_full;
  logic             next_not_full;
  logic             push;
  logic             pop;

  assign push          = port.in_valid && not_full;
  assign pop           = port.out_ready && (count != '0);
  assign port.in_ready = not_full;
  assign port.out_valid = (count != '0);
  assign port.out_data = mem[rd_ptr];

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
    // Registered so the upstream ready is glitch free
    next_not_full = (next_count != (AW+1)'(DEPTH));
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      not_full <= 1'b1;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      not_full <= next_not_full;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= port.in_data;
    end
  end
endmodule // sample_fifo

//--- adc_sequencer.sv
/*
  Digital sequencer of a dual converter: power-up calibration wait, pin and
  command calibration, fixed-length calibration run, pipeline delay and 1:2
  demultiplexing of I and Q results onto primary and delayed buses.
  Assumes conversion results arrive one per core_clk from the same domain;
  calibration and control pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
`include "adc_seq_consts.svh"

module adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter int          PIPE_LAT    = `PIPE_LATENCY,
  parameter int          CAL_CYCLES  = `CAL_RUN_CYCLES,
  parameter logic [63:0] WAIT_SHORT  = `WAIT_SHORT_CYCLES,
  parameter logic [63:0] WAIT_LONG   = `WAIT_LONG_CYCLES
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  // Conversion results
  input  wire adc_seq_pkg::sample_t sample_i,
  input  wire adc_seq_pkg::sample_t sample_q,
  input  wire logic                 sample_valid,
  output logic                      sample_ready,
  // Control pins and command
  input  wire logic                 cal_pin,
  input  wire logic                 cal_delay_select,
  input  wire logic                 power_down_input,
  input  wire logic                 cal_command,
  // Output buses
  output adc_seq_pkg::sample_t      i_primary_bus,
  output adc_seq_pkg::sample_t      i_delayed_bus,
  output adc_seq_pkg::sample_t      q_primary_bus,
  output adc_seq_pkg::sample_t      q_delayed_bus,
  output logic                      bus_update,
  input  wire logic                 capture_ready,
  // Status
  output logic                      calibrating
);
  // Delay line, FIFO write and output register together make up PIPE_LAT + 1 edges
  localparam int DELAY_STAGES = (PIPE_LAT > 2) ? PIPE_LAT - 1 : 1;
  localparam int PW = `PULSE_CNT_WIDTH;
  localparam int WW = `WAIT_CNT_WIDTH;
  localparam int CW = $clog2(CAL_CYCLES + 1);

  // Pin synchronisers
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       pin_cal;
  logic       pin_sel;
  logic       pin_pd;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {cal_pin, cal_delay_select, power_down_input};
      sync_b <= sync_a;
    end
  end
  assign {pin_cal, pin_sel, pin_pd} = sync_b;

  // Calibration pulse qualifier
  logic [PW-1:0] low_cnt, next_low_cnt;
  logic [PW-1:0] high_cnt, next_high_cnt;
  logic          low_ok, next_low_ok;
  logic          pin_req, next_pin_req;

  always_comb begin
    next_low_cnt  = low_cnt;
    next_high_cnt = '0;
    next_low_ok   = low_ok;
    next_pin_req  = 1'b0;
    if (!pin_cal) begin
      next_low_cnt = (low_cnt == PW'(`CAL_LOW_MIN)) ? low_cnt : low_cnt + 1'b1;
      if (low_cnt == PW'(`CAL_LOW_MIN - 1)) begin
        next_low_ok = 1'b1;
      end
    end else begin
      next_low_cnt = '0;
      if (low_ok) begin
        next_high_cnt = high_cnt + 1'b1;
        if (high_cnt == PW'(`CAL_HIGH_MIN - 1)) begin
          next_pin_req  = 1'b1;
          next_low_ok   = 1'b0;
          next_high_cnt = '0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      low_cnt  <= '0;
      high_cnt <= '0;
      low_ok   <= 1'b0;
      pin_req  <= 1'b0;
    end else begin
      low_cnt  <= next_low_cnt;
      high_cnt <= next_high_cnt;
      low_ok   <= next_low_ok;
      pin_req  <= next_pin_req;
    end
  end

  // Calibration sequencing
  cal_state_t    state, next_state;
  logic [WW-1:0] wait_cnt, next_wait_cnt;
  logic [CW-1:0] cal_cnt, next_cal_cnt;
  logic [1:0]    settle, next_settle;
  logic          held_off, next_held_off;
  logic          next_calibrating;
  logic          cal_req;
  logic [WW-1:0] wait_limit;

  assign cal_req    = pin_req || cal_command;
  assign wait_limit = pin_sel ? WW'(WAIT_LONG) : WW'(WAIT_SHORT);

  always_comb begin
    next_state    = state;
    next_wait_cnt = wait_cnt;
    next_cal_cnt  = cal_cnt;
    next_settle   = (settle == 2'h0) ? settle : settle - 2'h1;
    next_held_off = held_off;
    // Synchronisers still carry reset zeros for two edges, so the pin
    // level is caught only once real pin values have come through
    if (settle == 2'h1) begin
      next_held_off = pin_cal;
    end
    case (state)
      ST_POWERUP: begin
        if (!pin_pd && settle == 2'h0) begin
          next_wait_cnt = wait_cnt + 1'b1;
        end
        if (!pin_pd && settle == 2'h0 && ((cal_req && held_off) ||
            (!held_off && next_wait_cnt >= wait_limit))) begin
          next_state    = ST_CAL;
          next_cal_cnt  = '0;
          next_held_off = 1'b0;
        end
      end
      ST_NORMAL: begin
        if (cal_req && !pin_pd) begin
          next_state   = ST_CAL;
          next_cal_cnt = '0;
        end
      end
      ST_CAL: begin
        next_cal_cnt = cal_cnt + 1'b1;
        if (cal_cnt == CW'(CAL_CYCLES - 1)) begin
          next_state = ST_NORMAL;
        end
      end
      default: next_state = ST_POWERUP;
    endcase
    next_calibrating = (next_state == ST_CAL);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state       <= ST_POWERUP;
      wait_cnt    <= '0;
      cal_cnt     <= '0;
      settle      <= 2'h3;
      held_off    <= 1'b0;
      calibrating <= 1'b0;
    end else begin
      state       <= next_state;
      wait_cnt    <= next_wait_cnt;
      cal_cnt     <= next_cal_cnt;
      settle      <= next_settle;
      held_off    <= next_held_off;
      calibrating <= next_calibrating;
    end
  end

  // Pipeline delay line; it never stops, so results keep flowing every cycle
  pair_t pipe [DELAY_STAGES];
  logic  pipe_vld [DELAY_STAGES];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < DELAY_STAGES; k++) begin
        pipe[k]     <= '0;
        pipe_vld[k] <= 1'b0;
      end
    end else begin
      pipe[0]     <= '{i_word: sample_i, q_word: sample_q};
      pipe_vld[0] <= sample_valid;
      for (int k = 1; k < DELAY_STAGES; k++) begin
        pipe[k]     <= pipe[k-1];
        pipe_vld[k] <= pipe_vld[k-1];
      end
    end
  end

  fifo_if #(.WIDTH($bits(pair_t))) fq ();

  assign fq.in_valid  = pipe_vld[DELAY_STAGES-1];
  assign fq.in_data   = pipe[DELAY_STAGES-1];
  assign fq.out_ready = capture_ready;

  sample_fifo #(
    .WIDTH ($bits(pair_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .reset    (reset),
    .port     (fq.fifo)
  );

  // 1:2 demultiplexer
  pair_t   hold, next_hold, head;
  logic    phase, next_phase;
  sample_t next_ip, next_id, next_qp, next_qd;
  logic    next_update;

  assign head = fq.out_data;

  always_comb begin
    next_hold   = hold;
    next_phase  = phase;
    next_ip     = i_primary_bus;
    next_id     = i_delayed_bus;
    next_qp     = q_primary_bus;
    next_qd     = q_delayed_bus;
    next_update = 1'b0;
    if (fq.out_valid && capture_ready) begin
      next_phase = ~phase;
      if (!phase) begin
        next_hold = head;
      end else begin
        // Held word waited one cycle longer than the word now leaving
        next_id     = hold.i_word;
        next_qd     = hold.q_word;
        next_ip     = head.i_word;
        next_qp     = head.q_word;
        next_update = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hold          <= '0;
      phase         <= 1'b0;
      i_primary_bus <= '0;
      i_delayed_bus <= '0;
      q_primary_bus <= '0;
      q_delayed_bus <= '0;
      bus_update    <= 1'b0;
      sample_ready  <= 1'b1;
    end else begin
      hold          <= next_hold;
      phase         <= next_phase;
      i_primary_bus <= next_ip;
      i_delayed_bus <= next_id;
      q_primary_bus <= next_qp;
      q_delayed_bus <= next_qd;
      bus_update    <= next_update;
      sample_ready  <= fq.in_ready;
    end
  end
endmodule // adc_sequencer

//--- adc_seq_checker.sv
/*
  Checker for the converter sequencer: bus pacing, latency, calibration.
  Assumes a bind to adc_sequencer; latency checks need a steady stream.
*/
`timescale 1ns/1ns

module adc_seq_checker
  import adc_seq_pkg::*;
#(
  parameter int          PIPE_LAT   = 13,
  parameter int          CAL_CYCLES = 20,
  parameter logic [63:0] WAIT_SHORT = 64'h1e,
  parameter logic [63:0] WAIT_LONG  = 64'h3c
) (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 reset,
  // Inputs
  input wire adc_seq_pkg::sample_t sample_i,
  input wire logic                 sample_valid,
  input wire logic                 capture_ready,
  input wire logic                 cal_command,
  input wire logic                 cal_delay_select,
  input wire logic                 power_down_input,
  // Outputs
  input wire adc_seq_pkg::sample_t i_primary_bus,
  input wire adc_seq_pkg::sample_t i_delayed_bus,
  input wire logic                 bus_update,
  input wire logic                 calibrating
);
  int   run_len, stream, pd_run, since;
  logic done_once, cmd_seen;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      run_len   <= 0;
      stream    <= 0;
      pd_run    <= 0;
      since     <= 0;
      done_once <= 1'h0;
      cmd_seen  <= 1'h0;
    end else begin
      run_len   <= calibrating ? run_len + 1 : 0;
      stream    <= (sample_valid && capture_ready) ? stream + 1 : 0;
      pd_run    <= power_down_input ? pd_run + 1 : 0;
      since     <= since + 1;
      done_once <= done_once || (run_len != 0 && !calibrating);
      cmd_seen  <= cmd_seen || cal_command;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence cal_end;
    calibrating ##1 !calibrating;
  endsequence
  // A stalled FIFO stretches latency, so only a long unbroken run counts
  sequence steady_pair;
    bus_update && stream > PIPE_LAT + 6;
  endsequence

  update_spacing_a: assert property (bus_update |=> !bus_update)
    else $error("bus update on two cycles in a row");
  buses_hold_a: assert property (!bus_update |-> $stable(i_primary_bus))
    else $error("primary bus moved without an update");
  primary_lat_a: assert property (steady_pair |-> i_primary_bus == $past(sample_i, PIPE_LAT + 1))
    else $error("primary bus latency wrong");
  delayed_lat_a: assert property (steady_pair |-> i_delayed_bus == $past(sample_i, PIPE_LAT + 2))
    else $error("delayed bus latency wrong");
  cal_length_a: assert property (cal_end |-> run_len == CAL_CYCLES)
    else $error("calibration ended at the wrong count");
  cal_bound_a: assert property (calibrating |-> run_len < CAL_CYCLES)
    else $error("calibration ran too long");
  pd_block_a: assert property ($rose(calibrating) |-> pd_run < 4)
    else $error("calibration started in power down");
  cmd_start_a: assert property (cal_command && done_once && !calibrating && pd_run == 0
                                |-> ##[1:2] calibrating)
    else $error("command did not start calibration");
  wait_short_a: assert property ($rose(calibrating) && !done_once && !cmd_seen
                                 && !cal_delay_select |-> since >= WAIT_SHORT)
    else $error("short power-up wait cut short");
  wait_long_a: assert property ($rose(calibrating) && !done_once && !cmd_seen
                                && cal_delay_select |-> since >= WAIT_LONG)
    else $error("long power-up wait cut short");
endmodule // adc_seq_checker

//--- capture_model.sv
/*
  Capture-side model: counts words on bus_update, drives the calibration pin
  and the drain handshake. Assumes tasks are called at falling edges.
*/
`timescale 1ns/1ns

module capture_model (
  // Clock
  input  wire logic core_clk,
  // From the converter
  input  wire logic bus_update,
  // Controls
  output logic      cal_pin,
  output logic      capture_ready
);
  int words = 0;

  initial begin
    cal_pin = 1'h0;
    capture_ready = 1'h1;
  end

  always @(posedge core_clk) if (bus_update === 1'h1) words <= words + 2;

  task automatic set_pin(logic v);
    cal_pin = v;
  endtask

  task automatic set_ready(logic v);
    capture_ready = v;
  endtask

  // Extra cycles model a slow controller stretching both phases
  task automatic cal_pulse(int extra);
    cal_pin = 1'h0;
    repeat (1280 + extra) @(negedge core_clk);
    cal_pin = 1'h1;
    repeat (1280 + extra) @(negedge core_clk);
  endtask
endmodule // capture_model

//--- tb_top.sv
/*
  Bench for the converter sequencer: power-up waits, calibration starts,
  pipeline timing and the FIFO. Assumes capture_model and short counts.
*/
`timescale 1ns/1ns

module tb_top;
  import adc_seq_pkg::*;
  localparam int CALN = 20;
  localparam int WS   = 30;
  localparam int WL   = 60;

  logic    core_clk, reset, sample_valid, cal_command, cal_delay_select, power_down_input;
  logic    sample_ready, bus_update, calibrating, cal_pin, capture_ready;
  sample_t sample_i, sample_q, i_primary_bus, i_delayed_bus, q_primary_bus, q_delayed_bus;
  int      cyc, mismatches, cmp_count;

  adc_sequencer #(.CAL_CYCLES(CALN), .WAIT_SHORT(WS), .WAIT_LONG(WL)) DUT (
    .core_clk, .reset, .sample_i, .sample_q, .sample_valid, .sample_ready, .cal_pin,
    .cal_delay_select, .power_down_input, .cal_command, .i_primary_bus, .i_delayed_bus,
    .q_primary_bus, .q_delayed_bus, .bus_update, .capture_ready, .calibrating);
  capture_model cap (.core_clk, .bus_update, .cal_pin, .capture_ready);

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  // Each word carries the edge number at which it is taken
  always @(negedge core_clk) begin
    sample_i <= cyc[7:0] + 8'h1;
    sample_q <= ~(cyc[7:0] + 8'h1);
  end

  task automatic cmp_num(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_word(sample_t got, sample_t exp);
    cmp_num({24'h0, got}, {24'h0, exp});
  endtask

  task automatic do_reset(logic sel, logic pd, logic pin);
    @(negedge core_clk);
    reset = 1'h1;
    cal_delay_select = sel;
    power_down_input = pd;
    cap.set_pin(pin);
    repeat (2) @(negedge core_clk);
    reset = 1'h0;
  endtask

  // Start must land at lo to hi - 1 cycles, then the run must last CALN
  task automatic measure_cal(int lo, int hi);
    int n, m;
    n = 0;
    m = 0;
    while (calibrating !== 1'h1 && n < hi) begin
      @(negedge core_clk);
      n++;
    end
    cmp_num(n >= lo && n < hi, 1);
    while (calibrating === 1'h1 && m < 4 * CALN) begin
      @(negedge core_clk);
      m++;
    end
    cmp_num(m, CALN);
  endtask

  task automatic t_data;
    int ups;
    ups = 0;
    repeat (20) @(negedge core_clk);
    repeat (40) begin
      @(negedge core_clk);
      if (bus_update === 1'h1) begin
        ups++;
        cmp_word(i_primary_bus, cyc[7:0] - 8'hd);
        cmp_word(q_primary_bus, ~(cyc[7:0] - 8'hd));
        cmp_word(i_delayed_bus, cyc[7:0] - 8'he);
        cmp_word(q_delayed_bus, ~(cyc[7:0] - 8'he));
      end
    end
    cmp_num(ups, 20);
  endtask

  task automatic t_cmd;
    @(negedge core_clk);
    cal_command = 1'h1;
    @(negedge core_clk);
    cal_command = 1'h0;
    measure_cal(0, 4);
  endtask

  task automatic t_fifo;
    cap.set_ready(1'h0);
    repeat (20) @(negedge core_clk);
    cmp_num(sample_ready, 0);
    sample_valid = 1'h0;
    cap.set_ready(1'h1);
    repeat (20) @(negedge core_clk);
    cmp_num(sample_ready, 1);
    sample_valid = 1'h1;
    t_data();
  endtask

  task automatic t_pd;
    do_reset(1'h0, 1'h1, 1'h0);
    repeat (100) @(negedge core_clk);
    cmp_num(calibrating, 0);
    power_down_input = 1'h0;
    measure_cal(WS - 2, WS + 9);
  endtask

  task automatic t_hold;
    do_reset(1'h0, 1'h0, 1'h1);
    repeat (100) @(negedge core_clk);
    cmp_num(calibrating, 0);
    fork
      cap.cal_pulse(7);
      begin
        // Stretched high phase outlasts the trigger, so time from the pin rise
        repeat (1287) @(negedge core_clk);
        measure_cal(1280, 1288);
      end
    join
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    core_clk = 1'h0;
    reset = 1'h1;
    sample_valid = 1'h1;
    cal_command = 1'h0;
    cal_delay_select = 1'h0;
    power_down_input = 1'h0;
    sample_i = 8'h0;
    sample_q = 8'hff;
    cyc = 0;
    mismatches = 0;
    cmp_count = 0;
    do_reset(1'h0, 1'h0, 1'h0);
    measure_cal(WS - 2, WS + 9);
    t_data();
    t_cmd();
    cap.cal_pulse(0);
    measure_cal(0, 8);
    t_fifo();
    do_reset(1'h1, 1'h0, 1'h0);
    measure_cal(WL - 2, WL + 9);
    t_pd();
    t_hold();
    complete_run();
  end

  // Whole run is about 6000 cycles
  initial begin
    #160000;
    mismatches++;
    complete_run();
  end
endmodule // tb_top

bind adc_sequencer adc_seq_checker #(.PIPE_LAT(PIPE_LAT), .CAL_CYCLES(CAL_CYCLES),
  .WAIT_SHORT(WAIT_SHORT), .WAIT_LONG(WAIT_LONG)) chk (.core_clk, .reset, .sample_i,
  .sample_valid, .capture_ready, .cal_command, .cal_delay_select, .power_down_input,
  .i_primary_bus, .i_delayed_bus, .bus_update, .calibrating);
